// ===== verilog/lpcs_control.sv
// Contract
// RULE1 - 1 to 16 edges form data
// RULE2 - over 16 edges form address, minus 17
// RULE3 - latch only after pin high timeout
// RULE4 - host sends address, wait, data, wait
// RULE5 - address kept for later data bursts
// RULE6 - long low enters shutdown, outputs off
// RULE7 - after shutdown address starts at 0
// RULE8 - level registers are 4 bits
// RULE9 - value 1 full, 16 zero current
// RULE10 - scale register picks per-sink HI or LO
// RULE11 - power data 1 on, 2 standby
// RULE12 - mode data 2 selects voltage mode
// RULE13 - nonzero sink level overrides voltage mode
// RULE14 - return data 1 restores current mode
// RULE15 - logic timed by 1MHz oscillator tick
// RULE16 - address 0 both, 1 first, 2 second
// RULE17 - scale data 1 to 4 mapping
// RULE18 - shutdown resets every register
// RULE19 - timeouts counted in oscillator ticks
// RULE20 - undefined addresses change nothing
`timescale 1ns/1ps
module lpcs_control #(
   parameter int LAT_TICKS = lpcs_pkg::LAT_TICKS,
   parameter int OFF_TICKS = lpcs_pkg::OFF_TICKS
) (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic ctrl_pin_in,
   output logic [3:0] first_current_sink_level_out,
   output logic [3:0] second_current_sink_level_out,
   output logic first_current_sink_hi_out,
   output logic second_current_sink_hi_out,
   output logic first_current_sink_en_out,
   output logic second_current_sink_en_out,
   output logic [8:0] first_current_sink_ma_out,
   output logic [8:0] second_current_sink_ma_out,
   output logic voltage_mode_out,
   output logic standby_out,
   output logic shutdown_out
);
   // ==========================================
   // elaboration checks
   // timeouts must outlast the longest legal pulse and stay within spec
   if (LAT_TICKS <= lpcs_pkg::PULSE_MAX_TICKS ||
       LAT_TICKS > lpcs_pkg::TIMEOUT_MAX_TICKS) begin : g_bad_lat
      $error("latch timeout out of range");
   end
   if (OFF_TICKS <= lpcs_pkg::PULSE_MAX_TICKS ||
       OFF_TICKS > lpcs_pkg::TIMEOUT_MAX_TICKS) begin : g_bad_off
      $error("off timeout out of range");
   end

   // ==========================================
   // declarations
   logic osc_tick;
   logic pin_prev_q;
   logic rise;
   logic [8:0] hi_cnt_q;
   logic [8:0] lo_cnt_q;
   logic [5:0] edge_cnt_q;
   logic latch_p;
   logic off_p;
   logic is_data;
   logic data_wr;
   logic addr_wr;
   logic [3:0] data_code;
   logic [5:0] addr_q;
   logic shutdown_q;
   logic [3:0] lvl1_q;
   logic [3:0] lvl2_q;
   logic hi1_q;
   logic hi2_q;
   logic power_on_q;
   logic vmode_q;
   logic override;
   logic v_act;
   logic en1;
   logic en2;
   logic [3:0] rom1_code;
   logic [3:0] rom2_code;

   // ==========================================
   // oscillator tick
   lpcs_tick_div #(
      .DIV(lpcs_pkg::OSC_DIV)
   ) u_osc (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .tick_out(osc_tick)
   );

   // ==========================================
   // pin edge detect
   // pin is already synchronous, one stage of history suffices
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_prev_q <= 1'b0;
      end else begin
         pin_prev_q <= ctrl_pin_in;
      end
   end

   assign rise = ctrl_pin_in & ~pin_prev_q;

   // ==========================================
   // high and low timers
   // high time restarts at every rising edge so only the last one counts
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hi_cnt_q <= 9'h000;
      end else if (!ctrl_pin_in || rise) begin
         hi_cnt_q <= 9'h000;
      end else if (osc_tick && hi_cnt_q != 9'(LAT_TICKS)) begin // [RULE19]
         hi_cnt_q <= hi_cnt_q + 9'h001;
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lo_cnt_q <= 9'h000;
      end else if (ctrl_pin_in) begin
         lo_cnt_q <= 9'h000;
      end else if (osc_tick && lo_cnt_q != 9'(OFF_TICKS)) begin // [RULE19]
         lo_cnt_q <= lo_cnt_q + 9'h001;
      end
   end

   // saturating timers fire exactly once per idle period
   assign latch_p = osc_tick & ctrl_pin_in & (edge_cnt_q != 6'h00)
      & (hi_cnt_q == 9'(LAT_TICKS - 1)); // [RULE3] [RULE15]
   assign off_p = osc_tick & ~ctrl_pin_in & ~shutdown_q
      & (lo_cnt_q == 9'(OFF_TICKS - 1)); // [RULE6] [RULE15]

   // ==========================================
   // edge counter
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         edge_cnt_q <= 6'h00;
      end else if (latch_p || off_p) begin
         edge_cnt_q <= 6'h00;
      end else if (rise && edge_cnt_q != lpcs_pkg::EDGE_SAT) begin
         edge_cnt_q <= edge_cnt_q + 6'h01;
      end
   end

   assign is_data = edge_cnt_q <= lpcs_pkg::DATA_MAX_EDGES; // [RULE1] [RULE2]
   assign data_wr = latch_p & is_data;
   assign addr_wr = latch_p & ~is_data;
   assign data_code = 4'(edge_cnt_q - 6'h01); // [RULE8]

   // ==========================================
   // shutdown state
   // a rising edge wakes the device; that edge already counts
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shutdown_q <= 1'b1;
      end else if (off_p) begin
         shutdown_q <= 1'b1; // [RULE6]
      end else if (rise) begin
         shutdown_q <= 1'b0;
      end
   end

   // ==========================================
   // address register
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         addr_q <= lpcs_pkg::ADDR_RESET;
      end else if (off_p) begin
         addr_q <= lpcs_pkg::ADDR_RESET; // [RULE7] [RULE18]
      end else if (addr_wr) begin
         addr_q <= edge_cnt_q - lpcs_pkg::ADDR_BASE_EDGES; // [RULE2]
      end
   end

   // ==========================================
   // sink level registers
   // data writes leave addr_q alone, so bursts repeat to it
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lvl1_q <= lpcs_pkg::LEVEL_RESET;
         lvl2_q <= lpcs_pkg::LEVEL_RESET;
      end else if (off_p) begin
         lvl1_q <= lpcs_pkg::LEVEL_RESET; // [RULE18]
         lvl2_q <= lpcs_pkg::LEVEL_RESET;
      end else if (data_wr) begin // [RULE5]
         if (addr_q == lpcs_pkg::ADDR_DUAL_SINK_LEVEL ||
             addr_q == lpcs_pkg::ADDR_FIRST_SINK_LEVEL) begin
            lvl1_q <= data_code; // [RULE16] [RULE1]
         end
         if (addr_q == lpcs_pkg::ADDR_DUAL_SINK_LEVEL ||
             addr_q == lpcs_pkg::ADDR_SECOND_SINK_LEVEL) begin
            lvl2_q <= data_code; // [RULE16]
         end
      end
   end

   // ==========================================
   // scale register
   // data beyond 4 is ignored
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hi1_q <= lpcs_pkg::SCALE_HI_RESET;
         hi2_q <= lpcs_pkg::SCALE_HI_RESET;
      end else if (off_p) begin
         hi1_q <= lpcs_pkg::SCALE_HI_RESET; // [RULE18]
         hi2_q <= lpcs_pkg::SCALE_HI_RESET;
      end else if (data_wr && addr_q == lpcs_pkg::ADDR_SCALE_SELECT) begin
         unique case (data_code) // [RULE10] [RULE17]
            lpcs_pkg::CODE_1: begin
               hi1_q <= 1'b0;
               hi2_q <= 1'b0;
            end
            lpcs_pkg::CODE_2: begin
               hi1_q <= 1'b1;
               hi2_q <= 1'b1;
            end
            lpcs_pkg::CODE_3: begin
               hi1_q <= 1'b0;
               hi2_q <= 1'b1;
            end
            lpcs_pkg::CODE_4: begin
               hi1_q <= 1'b1;
               hi2_q <= 1'b0;
            end
            default: begin
               hi1_q <= hi1_q;
               hi2_q <= hi2_q;
            end
         endcase
      end
   end

   // ==========================================
   // power register
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         power_on_q <= lpcs_pkg::SINK_POWER_RESET;
      end else if (off_p) begin
         power_on_q <= lpcs_pkg::SINK_POWER_RESET; // [RULE18]
      end else if (data_wr && addr_q == lpcs_pkg::ADDR_SINK_POWER) begin
         if (data_code == lpcs_pkg::CODE_1) begin
            power_on_q <= 1'b1; // [RULE11]
         end else if (data_code == lpcs_pkg::CODE_2) begin
            power_on_q <= 1'b0; // [RULE11]
         end
      end
   end

   // ==========================================
   // voltage mode register
   // both return paths are honoured since either may be used by software
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         vmode_q <= lpcs_pkg::VMODE_RESET;
      end else if (off_p) begin
         vmode_q <= lpcs_pkg::VMODE_RESET; // [RULE18]
      end else if (data_wr) begin
         if (addr_q == lpcs_pkg::ADDR_VOLTAGE_MODE_SELECT &&
             data_code == lpcs_pkg::CODE_2) begin
            vmode_q <= 1'b1; // [RULE12]
         end else if ((addr_q == lpcs_pkg::ADDR_VOLTAGE_MODE_SELECT ||
                       addr_q == lpcs_pkg::ADDR_CURRENT_MODE_RETURN) &&
                      data_code == lpcs_pkg::CODE_1) begin
            vmode_q <= 1'b0; // [RULE14]
         end
      end
   end

   // ==========================================
   // output decode
   assign override = (lvl1_q != lpcs_pkg::LEVEL_ZERO) |
      (lvl2_q != lpcs_pkg::LEVEL_ZERO); // [RULE13]
   assign v_act = vmode_q & ~override & ~shutdown_q; // [RULE13]
   assign en1 = ~shutdown_q & power_on_q
      & (lvl1_q != lpcs_pkg::LEVEL_ZERO); // [RULE9] [RULE6]
   assign en2 = ~shutdown_q & power_on_q
      & (lvl2_q != lpcs_pkg::LEVEL_ZERO);
   assign rom1_code = en1 ? lvl1_q : lpcs_pkg::LEVEL_ZERO;
   assign rom2_code = en2 ? lvl2_q : lpcs_pkg::LEVEL_ZERO;

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         first_current_sink_level_out <= lpcs_pkg::LEVEL_RESET;
         second_current_sink_level_out <= lpcs_pkg::LEVEL_RESET;
         first_current_sink_hi_out <= lpcs_pkg::SCALE_HI_RESET;
         second_current_sink_hi_out <= lpcs_pkg::SCALE_HI_RESET;
         first_current_sink_en_out <= 1'b0;
         second_current_sink_en_out <= 1'b0;
         voltage_mode_out <= 1'b0;
         standby_out <= 1'b0;
         shutdown_out <= 1'b1;
      end else begin
         first_current_sink_level_out <= lvl1_q;
         second_current_sink_level_out <= lvl2_q;
         first_current_sink_hi_out <= hi1_q;
         second_current_sink_hi_out <= hi2_q;
         first_current_sink_en_out <= en1;
         second_current_sink_en_out <= en2;
         voltage_mode_out <= v_act; // [RULE12]
         standby_out <= ~shutdown_q & ~power_on_q;
         shutdown_out <= shutdown_q;
      end
   end

   // ==========================================
   // current lookup
   lpcs_level_rom u_rom1 (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .code_in(rom1_code),
      .hi_in(hi1_q),
      .ma_out(first_current_sink_ma_out)
   );

   lpcs_level_rom u_rom2 (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .code_in(rom2_code),
      .hi_in(hi2_q),
      .ma_out(second_current_sink_ma_out)
   );

   // ==========================================
   // checks
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   chk_data_write: assert property ( // [RULE1]
      data_wr && addr_q == lpcs_pkg::ADDR_FIRST_SINK_LEVEL
      |=> lvl1_q == $past(data_code) ##1
          first_current_sink_level_out == $past(lvl1_q))
      else $error("data burst not written to first sink");

   chk_addr_write: assert property ( // [RULE2]
      addr_wr |=> addr_q == $past(edge_cnt_q) - 6'h11)
      else $error("address burst decoded wrong");

   chk_latch_wait: assert property ( // [RULE3]
      latch_p |-> ctrl_pin_in && hi_cnt_q == 9'(LAT_TICKS - 1))
      else $error("latch before timeout");

   chk_addr_kept: assert property ( // [RULE5]
      data_wr |=> $stable(addr_q))
      else $error("address changed on data write");

   chk_off_outputs: assert property ( // [RULE6]
      off_p |=> shutdown_q ##1 shutdown_out
         && !first_current_sink_en_out && !second_current_sink_en_out)
      else $error("off timeout did not shut down");

   chk_reset_regs: assert property ( // [RULE18]
      off_p |=> addr_q == 6'h00 && lvl1_q == 4'hF && lvl2_q == 4'hF
         && power_on_q && !vmode_q && !hi1_q && !hi2_q)
      else $error("shutdown did not restore defaults");

   chk_scale_four: assert property ( // [RULE17]
      data_wr && addr_q == lpcs_pkg::ADDR_SCALE_SELECT && data_code == 4'h3
      |=> hi1_q && !hi2_q)
      else $error("scale data 4 wrong");

   chk_power_off: assert property ( // [RULE11]
      data_wr && addr_q == lpcs_pkg::ADDR_SINK_POWER && data_code == 4'h1
      |=> ##1 standby_out && !first_current_sink_en_out)
      else $error("power off not applied");

   chk_override: assert property ( // [RULE13]
      voltage_mode_out |-> $past(lvl1_q) == 4'hF && $past(lvl2_q) == 4'hF)
      else $error("voltage mode with sink active");

   chk_tick_gap: assert property ( // [RULE15]
      osc_tick |=> !osc_tick [*8])
      else $error("oscillator tick too frequent");

   chk_unmapped: assert property ( // [RULE20]
      data_wr && addr_q > 6'h06 |=> $stable(lvl1_q) && $stable(vmode_q)
         && $stable(power_on_q) && $stable(hi1_q))
      else $error("unmapped write changed state");
endmodule

// ===== verilog/lpcs_pkg.sv
package lpcs_pkg;
   // ==========================================
   // clocks and internal oscillator
   localparam int CLK_HZ = 125_000_000;
   localparam int OSC_HZ = 1_000_000;
   localparam int OSC_DIV = CLK_HZ / OSC_HZ;
   // ==========================================
   // timeouts, measured in oscillator ticks
   localparam int US_PER_S = 1_000_000;
   localparam int PULSE_MAX_US = 60;
   localparam int TIMEOUT_MAX_US = 500;
   localparam int LAT_TIME_US = 200;
   localparam int OFF_TIME_US = 200;
   localparam int LAT_TICKS = LAT_TIME_US * OSC_HZ / US_PER_S;
   localparam int OFF_TICKS = OFF_TIME_US * OSC_HZ / US_PER_S;
   localparam int PULSE_MAX_TICKS = PULSE_MAX_US * OSC_HZ / US_PER_S;
   localparam int TIMEOUT_MAX_TICKS = TIMEOUT_MAX_US * OSC_HZ / US_PER_S;
   // ==========================================
   // burst decode
   localparam logic [5:0] DATA_MAX_EDGES = 6'h10;
   localparam logic [5:0] ADDR_BASE_EDGES = 6'h11;
   localparam logic [5:0] EDGE_SAT = 6'h3F;
   // ==========================================
   // register addresses
   localparam logic [5:0] ADDR_DUAL_SINK_LEVEL = 6'h00;
   localparam logic [5:0] ADDR_FIRST_SINK_LEVEL = 6'h01;
   localparam logic [5:0] ADDR_SECOND_SINK_LEVEL = 6'h02;
   localparam logic [5:0] ADDR_SCALE_SELECT = 6'h03;
   localparam logic [5:0] ADDR_SINK_POWER = 6'h04;
   localparam logic [5:0] ADDR_CURRENT_MODE_RETURN = 6'h05;
   localparam logic [5:0] ADDR_VOLTAGE_MODE_SELECT = 6'h06;
   // ==========================================
   // data codes (edge count minus one) and reset values
   localparam logic [3:0] CODE_1 = 4'h0;
   localparam logic [3:0] CODE_2 = 4'h1;
   localparam logic [3:0] CODE_3 = 4'h2;
   localparam logic [3:0] CODE_4 = 4'h3;
   localparam logic [3:0] LEVEL_ZERO = 4'hF;
   localparam logic [3:0] LEVEL_RESET = LEVEL_ZERO;
   localparam logic [5:0] ADDR_RESET = ADDR_DUAL_SINK_LEVEL;
   localparam logic SINK_POWER_RESET = 1'b1;
   localparam logic SCALE_HI_RESET = 1'b0;
   localparam logic VMODE_RESET = 1'b0;
   // ==========================================
   // nominal sink current in mA per level code
   localparam logic [8:0] HI_MA [16] = '{
      9'h12C, 9'h10B, 9'h0EE, 9'h0D6, 9'h0BE, 9'h0A7, 9'h098, 9'h085,
      9'h077, 9'h069, 9'h05F, 9'h056, 9'h04C, 9'h043, 9'h03E, 9'h000};
   localparam logic [8:0] LO_MA [16] = '{
      9'h032, 9'h02C, 9'h028, 9'h024, 9'h020, 9'h01C, 9'h019, 9'h016,
      9'h014, 9'h011, 9'h010, 9'h00E, 9'h00D, 9'h00B, 9'h00A, 9'h000};
endpackage

// ===== verilog/lpcs_tick_div.sv
`timescale 1ns/1ps
module lpcs_tick_div #(
   parameter int DIV = lpcs_pkg::OSC_DIV
) (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   output logic tick_out
);
   // ==========================================
   // divider
   logic [7:0] cnt_q;

   if (DIV < 2 || DIV > 256) begin : g_bad_div
      $error("divider out of range");
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q <= 8'h00;
         tick_out <= 1'b0;
      end else if (cnt_q == 8'(DIV - 1)) begin
         cnt_q <= 8'h00;
         tick_out <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         tick_out <= 1'b0;
      end
   end
endmodule

// ===== verilog/lpcs_level_rom.sv
`timescale 1ns/1ps
module lpcs_level_rom (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic [3:0] code_in,
   input wire logic hi_in,
   output logic [8:0] ma_out
);
   // ==========================================
   // registered table read
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ma_out <= 9'h000;
      end else if (hi_in) begin
         ma_out <= lpcs_pkg::HI_MA[code_in];
      end else begin
         ma_out <= lpcs_pkg::LO_MA[code_in];
      end
   end
endmodule

// ===== bench/lpcs_host_model.sv
`timescale 1ns/1ps
module lpcs_host_model #(
   parameter int LAT_TICKS = 61,
   parameter int OFF_TICKS = 61
) (
   input wire logic sys_clk_in,
   output logic ctrl_pin_out
);
   // ==========================================
   // pin timing in system clocks
   localparam int TICK_CLKS = lpcs_pkg::OSC_DIV;
   // margin covers oscillator phase plus the output pipeline
   localparam int LAT_WAIT = (LAT_TICKS + 1) * TICK_CLKS + 16;
   localparam int OFF_WAIT = (OFF_TICKS + 2) * TICK_CLKS;

   initial begin
      ctrl_pin_out = 1'b0;
   end

   // ==========================================
   // pin sequences
   task automatic wait_clocks(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   // two clocks low, two high per edge: short but inside the pulse limits
   task automatic send_burst(input int edges);
      for (int i = 0; i < edges; i++) begin
         @(negedge sys_clk_in);
         ctrl_pin_out = 1'b0;
         repeat (2) @(negedge sys_clk_in);
         ctrl_pin_out = 1'b1;
         @(negedge sys_clk_in);
      end
   endtask

   task automatic write_value(input int edges);
      send_burst(edges);
      wait_clocks(LAT_WAIT);
   endtask

   task automatic write_reg(input int addr, input int data);
      write_value(17 + addr);
      write_value(data);
   endtask

   task automatic go_shutdown();
      @(negedge sys_clk_in);
      ctrl_pin_out = 1'b0;
      wait_clocks(OFF_WAIT);
   endtask
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ==========================================
   // setup
   localparam int LAT = 61;
   localparam int OFF = 61;
   localparam int TICK_CLKS = lpcs_pkg::OSC_DIV;
   localparam int MAX_CYCLES = 98000;
   logic sys_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic ctrl_pin;
   logic [3:0] lvl1;
   logic [3:0] lvl2;
   logic hi1;
   logic hi2;
   logic en1;
   logic en2;
   logic [8:0] ma1;
   logic [8:0] ma2;
   logic vmode;
   logic standby;
   logic shutdown;
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;

   always #4 sys_clk_in = ~sys_clk_in;

   lpcs_control #(
      .LAT_TICKS(LAT),
      .OFF_TICKS(OFF)
   ) u_lpcs_control (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .ctrl_pin_in(ctrl_pin),
      .first_current_sink_level_out(lvl1),
      .second_current_sink_level_out(lvl2),
      .first_current_sink_hi_out(hi1),
      .second_current_sink_hi_out(hi2),
      .first_current_sink_en_out(en1),
      .second_current_sink_en_out(en2),
      .first_current_sink_ma_out(ma1),
      .second_current_sink_ma_out(ma2),
      .voltage_mode_out(vmode),
      .standby_out(standby),
      .shutdown_out(shutdown)
   );

   lpcs_host_model #(
      .LAT_TICKS(LAT),
      .OFF_TICKS(OFF)
   ) u_lpcs_host_model (
      .sys_clk_in(sys_clk_in),
      .ctrl_pin_out(ctrl_pin)
   );

   // ==========================================
   // reporting
   task automatic check(input string what, input logic [8:0] seen,
                        input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // whole run is about 94k clocks; ceiling leaves a little slack
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == MAX_CYCLES) begin
         fail_count++;
         stop_test();
      end
   end

   // ==========================================
   // scenarios
   task automatic t_first_burst();
      u_lpcs_host_model.send_burst(5);
      u_lpcs_host_model.wait_clocks((LAT - 2) * TICK_CLKS);
      check("level1 before latch", 9'(lvl1), 9'h00F);
      u_lpcs_host_model.wait_clocks(3 * TICK_CLKS + 16);
      check("level1", 9'(lvl1), 9'h004);
      check("level2", 9'(lvl2), 9'h004);
      check("ma1 lo", ma1, 9'h020);
      check("en2", 9'(en2), 9'h001);
      check("shutdown", 9'(shutdown), 9'h000);
      $display("test first_burst done");
   endtask

   task automatic t_voltage_mode();
      u_lpcs_host_model.write_reg(6, 2);
      check("vmode overridden", 9'(vmode), 9'h000);
      u_lpcs_host_model.write_reg(0, 16);
      check("level1 zero", 9'(lvl1), 9'h00F);
      check("ma2 zero", ma2, 9'h000);
      check("en1 off", 9'(en1), 9'h000);
      check("vmode on", 9'(vmode), 9'h001);
      u_lpcs_host_model.write_value(1);
      check("vmode again off", 9'(vmode), 9'h000);
      check("level2 full", 9'(lvl2), 9'h000);
      $display("test voltage_mode done");
   endtask

   task automatic t_scale();
      u_lpcs_host_model.write_reg(3, 4);
      check("hi1", 9'(hi1), 9'h001);
      check("hi2", 9'(hi2), 9'h000);
      check("ma1 hi", ma1, 9'h12C);
      check("ma2 lo", ma2, 9'h032);
      $display("test scale done");
   endtask

   task automatic t_power();
      u_lpcs_host_model.write_reg(4, 2);
      check("standby", 9'(standby), 9'h001);
      check("en1 standby", 9'(en1), 9'h000);
      check("ma2 standby", ma2, 9'h000);
      $display("test power done");
   endtask

   // address was 4 before shutdown, so data-only must land on address 0
   task automatic t_shutdown();
      u_lpcs_host_model.go_shutdown();
      check("shutdown on", 9'(shutdown), 9'h001);
      check("en2 off", 9'(en2), 9'h000);
      check("level1 reset", 9'(lvl1), 9'h00F);
      check("hi1 reset", 9'(hi1), 9'h000);
      check("vmode reset", 9'(vmode), 9'h000);
      u_lpcs_host_model.write_value(3);
      check("level1 wake", 9'(lvl1), 9'h002);
      check("level2 wake", 9'(lvl2), 9'h002);
      check("standby reset", 9'(standby), 9'h000);
      check("en1 wake", 9'(en1), 9'h001);
      check("ma1 wake", ma1, 9'h028);
      $display("test shutdown done");
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (2) @(negedge sys_clk_in);
      arst_n_in = 1'b1;
      @(negedge sys_clk_in);
      check("shutdown at reset", 9'(shutdown), 9'h001);
      t_first_burst();
      t_voltage_mode();
      t_scale();
      t_power();
      t_shutdown();
      stop_test();
   end
endmodule
